// ===== hw/pmcr_pkg.sv
// Purpose: Constants for the power-management configuration register bank.
// Assumes: 8-bit special-function register bus with 8-bit addresses.
// Notes:   Offsets are byte addresses on the internal register bus.
package pmcr_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] PMCR_OFS_IRQ_EN   = 8'hec;
    localparam logic [7:0] PMCR_OFS_PERIPHERAL_CONFIG_STATUS   = 8'hf4;
    localparam logic [7:0] PMCR_OFS_POLICY   = 8'hf5;
    localparam logic [7:0] PMCR_OFS_RETAINED_SCRATCH_ONE = 8'hfb;
    localparam logic [7:0] PMCR_OFS_RETAINED_SCRATCH_TWO = 8'hfc;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PMCR_BIT_RX_WAKE    = 7;
    localparam int PMCR_BIT_RAIL_SRC   = 6;
    localparam int PMCR_BIT_SUPPLY_OK  = 5;
    localparam int PMCR_BIT_LOCK_FAULT = 4;
    localparam int PMCR_BIT_RESTORED   = 7;
    localparam int PMCR_BIT_SAG        = 5;
    localparam int PMCR_BIT_SWITCHOVER = 1;
    localparam int PMCR_BIT_DC_MON     = 0;

    // ************************************************************
    // Reset values and writable masks
    // ************************************************************
    localparam logic [1:0] PMCR_RST_POLICY   = 2'h0;
    localparam logic [1:0] PMCR_RST_RX_FUNC  = 2'h0;
    localparam logic [7:0] PMCR_RST_IRQ_EN   = 8'h00;
    localparam logic [7:0] PMCR_RST_SCRATCH  = 8'h00;
    localparam logic [7:0] PMCR_MASK_IRQ_EN  = 8'ha3;

    // Switchover policy and receive pin encodings.
    localparam logic [1:0] PMCR_POL_LOW_VDD  = 2'h0;
    localparam logic [1:0] PMCR_POL_LOW_BOTH = 2'h1;
    localparam logic [1:0] PMCR_RX_GPIO      = 2'h0;
    localparam logic [1:0] PMCR_RX_NO_WAKE   = 2'h1;
    localparam logic [1:0] PMCR_RX_WAKE      = 2'h3;

endpackage

// ===== hw/pmcr_regs.sv
// Purpose: Power-management special-function register bank.
// Assumes: Core register bus synchronous to CLK; status inputs synchronous.
// Notes:   Scratch pads use their own supply-loss reset, not RESET.
`timescale 1ns/1ps

// Summary of operation
// RL1: Policy field resets 00; 00 low supply, 01 supply or dc, 1x off.
// RL2: Software writes zero to policy bits 7..2; they read zero.
// RL3: Peripheral bit 7 set when receive edge woke core-off mode.
// RL4: Bit 6 reads switched rail source, 1 main, 0 battery.
// RL5: Bit 5 reads main supply good; reset value one.
// RL6: Bit 4 sticky lock-fault flag, set on lock loss.
// RL7: Acknowledge bit in register 0xD8 clears the lock-fault flag.
// RL8: Software keeps peripheral bits 3 and 2 zero.
// RL9: Receive pin function: 00 GPIO, 01 receive, 11 receive with wake.
// RL10: Enable bit 7 gates the supply-restored flag onto the interrupt.
// RL11: Enable bit 5 gates the voltage sag flag.
// RL12: Enable bit 1 gates the switchover flag.
// RL13: Enable bit 0 gates the dc monitor flag.
// RL14: Enable bits 4..2 kept clear by software; bit 6 reserved zero.
// RL15: Scratch pads are 8-bit read/write, reset zero, kept in power save.
// RL16: Scratch pads cleared only on loss of both supplies.
// RL17: Switchover flag set on change from main supply to battery.
// RL18: Dc monitor flag set when dc input drops below threshold.
// RL19: Interrupt asserted while any enabled flag is set.
module pmcr_regs
    import pmcr_pkg::*;
(
    input  wire logic       CLK,             // Core clock.
    input  wire logic       RESET,           // Sync reset, active high.
    input  wire logic       CLK_EN,          // Freezes state while low.
    input  wire logic       SUPPLY_LOSS_RST, // Both supplies lost, high.
    input  wire logic [7:0] SFR_ADDR,        // Register address.
    input  wire logic       SFR_WR,          // Write strobe.
    input  wire logic [7:0] SFR_WDATA,       // Write data.
    output logic      [7:0] SFR_RDATA,       // Read data.
    input  wire logic       RX_WAKE_EVENT,   // Receive edge woke the core.
    input  wire logic       RAIL_ON_MAIN,    // Rail fed by main supply.
    input  wire logic       MAIN_SUPPLY_OK,  // Main supply good.
    input  wire logic       LOCK_LOST,       // Multiplier lost lock pulse.
    input  wire logic       FAULT_ACK,       // Acknowledge write at 0xD8.
    input  wire logic       RESTORED_FLAG,   // Supply restored flag.
    input  wire logic       SAG_FLAG,        // Voltage sag flag.
    input  wire logic       SWITCHOVER_FLAG, // Switchover flag.
    input  wire logic       DC_MON_FLAG,     // Dc monitor flag.
    output logic      [1:0] SWITCH_POLICY,   // Policy field.
    output logic            SWITCH_ON_VDD,   // Switchover on low supply.
    output logic            SWITCH_ON_DC,    // Switchover also on low dc.
    output logic      [1:0] RX_PIN_FUNC,     // Receive pin function.
    output logic            RX_IS_SERIAL,    // Pin used as receive input.
    output logic            RX_WAKE_EN,      // Receive edges may wake.
    output logic            MONITOR_IRQ      // Monitor interrupt request.
);

    // ************************************************************
    // State
    // ************************************************************
    logic [1:0] policy_r,   policy_nxt;
    logic [1:0] rxfunc_r,   rxfunc_nxt;
    logic [7:0] irq_en_r,   irq_en_nxt;
    logic       rx_wake_r,  rx_wake_nxt;
    logic       fault_r,    fault_nxt;
    logic [7:0] retained_scratch_one_r, retained_scratch_one_nxt;
    logic [7:0] retained_scratch_two_r, retained_scratch_two_nxt;
    logic       rail_r,     rail_nxt;
    logic       supply_ok_r, supply_ok_nxt;
    logic       wr_peripheral_config_status,  wr_policy, wr_irq, wr_s1, wr_s2;

    // Address decode for writes. A core in reset issues no writes, and
    // gating them here keeps the pads untouched while RESET stands.
    assign wr_peripheral_config_status = SFR_WR && !RESET && (SFR_ADDR == PMCR_OFS_PERIPHERAL_CONFIG_STATUS);
    assign wr_policy = SFR_WR && !RESET && (SFR_ADDR == PMCR_OFS_POLICY);
    assign wr_irq    = SFR_WR && !RESET && (SFR_ADDR == PMCR_OFS_IRQ_EN);
    assign wr_s1     = SFR_WR && !RESET && (SFR_ADDR == PMCR_OFS_RETAINED_SCRATCH_ONE);
    assign wr_s2     = SFR_WR && !RESET && (SFR_ADDR == PMCR_OFS_RETAINED_SCRATCH_TWO);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // Control fields load on write; sticky flags give set priority over clear.
    always_comb begin
        policy_nxt   = policy_r;
        rxfunc_nxt   = rxfunc_r;
        irq_en_nxt   = irq_en_r;
        rx_wake_nxt  = rx_wake_r;
        fault_nxt    = fault_r;
        retained_scratch_one_nxt = retained_scratch_one_r;
        retained_scratch_two_nxt = retained_scratch_two_r;
        // RL4: rail source sampled
        rail_nxt      = RAIL_ON_MAIN;
        // RL5: supply good sampled
        supply_ok_nxt = MAIN_SUPPLY_OK;
        // RL1: policy field write
        if (wr_policy) begin
            policy_nxt = SFR_WDATA[1:0];
        end
        // RL9: receive pin function
        if (wr_peripheral_config_status) begin
            rxfunc_nxt = SFR_WDATA[1:0];
        end
        // RL14: reserved enables dropped
        if (wr_irq) begin
            irq_en_nxt = SFR_WDATA & PMCR_MASK_IRQ_EN;
        end
        // RL3: receive wake flag
        // Cleared by writing zero to bit 7; a wake event in the same
        // cycle wins so that no wake-up is lost.
        if (wr_peripheral_config_status && !SFR_WDATA[PMCR_BIT_RX_WAKE]) begin
            rx_wake_nxt = 1'b0;
        end
        if (RX_WAKE_EVENT) begin
            rx_wake_nxt = 1'b1;
        end
        // RL7: acknowledge clears fault
        if (FAULT_ACK) begin
            fault_nxt = 1'b0;
        end
        // RL6: lock loss sets fault
        if (LOCK_LOST) begin
            fault_nxt = 1'b1;
        end
        // RL15: scratch pad writes
        if (wr_s1) begin
            retained_scratch_one_nxt = SFR_WDATA;
        end
        if (wr_s2) begin
            retained_scratch_two_nxt = SFR_WDATA;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Main bank, set to its reset values by the ordinary reset.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            policy_r    <= PMCR_RST_POLICY;
            rxfunc_r    <= PMCR_RST_RX_FUNC;
            irq_en_r    <= PMCR_RST_IRQ_EN;
            rx_wake_r   <= 1'b0;
            fault_r     <= 1'b0;
            rail_r      <= 1'b1;
            supply_ok_r <= 1'b1;
        end else if (CLK_EN) begin
            policy_r    <= policy_nxt;
            rxfunc_r    <= rxfunc_nxt;
            irq_en_r    <= irq_en_nxt;
            rx_wake_r   <= rx_wake_nxt;
            fault_r     <= fault_nxt;
            rail_r      <= rail_nxt;
            supply_ok_r <= supply_ok_nxt;
        end
    end

    // RL16: scratch survives RESET
    // Only loss of both supplies clears the pads, so software, watchdog
    // and multiplier resets, all routed to RESET, leave them alone.
    always_ff @(posedge CLK) begin
        if (SUPPLY_LOSS_RST) begin
            retained_scratch_one_r <= PMCR_RST_SCRATCH;
            retained_scratch_two_r <= PMCR_RST_SCRATCH;
        end else if (CLK_EN) begin
            retained_scratch_one_r <= retained_scratch_one_nxt;
            retained_scratch_two_r <= retained_scratch_two_nxt;
        end
    end

    // ************************************************************
    // Read mux and outputs
    // ************************************************************
    // Unmapped addresses read zero; RL2 and RL8 bits read zero.
    always_comb begin
        case (SFR_ADDR)
            PMCR_OFS_IRQ_EN:   SFR_RDATA = irq_en_r;
            PMCR_OFS_PERIPHERAL_CONFIG_STATUS:   SFR_RDATA = {rx_wake_r, rail_r, supply_ok_r,
                                            fault_r, 2'h0, rxfunc_r};
            PMCR_OFS_POLICY:   SFR_RDATA = {6'h00, policy_r};
            PMCR_OFS_RETAINED_SCRATCH_ONE: SFR_RDATA = retained_scratch_one_r;
            PMCR_OFS_RETAINED_SCRATCH_TWO: SFR_RDATA = retained_scratch_two_r;
            default:           SFR_RDATA = 8'h00;
        endcase
    end

    // RL1: policy decode
    assign SWITCH_POLICY = policy_r;
    assign SWITCH_ON_VDD = (policy_r == PMCR_POL_LOW_VDD)
                        || (policy_r == PMCR_POL_LOW_BOTH);
    assign SWITCH_ON_DC  = (policy_r == PMCR_POL_LOW_BOTH);
    // RL9: pin function decode
    assign RX_PIN_FUNC   = rxfunc_r;
    assign RX_IS_SERIAL  = (rxfunc_r != PMCR_RX_GPIO);
    assign RX_WAKE_EN    = (rxfunc_r == PMCR_RX_WAKE);

    // RL19: enabled flags raise request
    // RL10 RL11 RL12 RL13: per-flag gates
    // RL17 RL18: flags come from the monitor
    assign MONITOR_IRQ =
        (irq_en_r[PMCR_BIT_RESTORED]   && RESTORED_FLAG)
     || (irq_en_r[PMCR_BIT_SAG]        && SAG_FLAG)
     || (irq_en_r[PMCR_BIT_SWITCHOVER] && SWITCHOVER_FLAG)
     || (irq_en_r[PMCR_BIT_DC_MON]     && DC_MON_FLAG);

    // ************************************************************
    // Assertions
    // ************************************************************
    fault_set_a: assert property (@(posedge CLK) disable iff (RESET) // RL6
        (CLK_EN && LOCK_LOST) |=> fault_r)
        else $error("lock fault not set");
    fault_ack_a: assert property (@(posedge CLK) disable iff (RESET) // RL7
        (CLK_EN && FAULT_ACK && !LOCK_LOST) |=> !fault_r)
        else $error("lock fault not cleared");
    fault_hold_a: assert property (@(posedge CLK) disable iff (RESET) // RL6
        (fault_r && !FAULT_ACK) |=> fault_r)
        else $error("lock fault lost");
    rx_wake_a: assert property (@(posedge CLK) disable iff (RESET) // RL3
        (CLK_EN && RX_WAKE_EVENT) |=> rx_wake_r)
        else $error("wake flag not set");
    policy_rd_a: assert property (@(posedge CLK) disable iff (RESET) // RL2
        (SFR_ADDR == PMCR_OFS_POLICY) |-> SFR_RDATA[7:2] == 6'h00)
        else $error("policy upper bits not zero");
    policy_wr_a: assert property (@(posedge CLK) disable iff (RESET) // RL1
        (CLK_EN && SFR_WR && SFR_ADDR == PMCR_OFS_POLICY)
        |=> SWITCH_POLICY == $past(SFR_WDATA[1:0]))
        else $error("policy write lost");
    rx_func_a: assert property (@(posedge CLK) disable iff (RESET) // RL9
        RX_WAKE_EN |-> RX_IS_SERIAL && RX_PIN_FUNC == PMCR_RX_WAKE)
        else $error("receive function decode");
    irq_gate_a: assert property (@(posedge CLK) disable iff (RESET) // RL12
        (irq_en_r[PMCR_BIT_SWITCHOVER] && SWITCHOVER_FLAG) |-> MONITOR_IRQ)
        else $error("irq not raised");
    irq_rsv_a: assert property (@(posedge CLK) disable iff (RESET) // RL14
        (irq_en_r & ~PMCR_MASK_IRQ_EN) == 8'h00)
        else $error("reserved enable set");
    scratch_keep_a: assert property (@(posedge CLK) // RL16
        (RESET && !SUPPLY_LOSS_RST) |=> retained_scratch_one_r == $past(retained_scratch_one_r))
        else $error("scratch changed by reset");

    // Status flags, sampled supplies and field decodes.
    rx_hold_a: assert property (@(posedge CLK) disable iff (RESET) // RL3
        (rx_wake_r && !RX_WAKE_EVENT && !wr_peripheral_config_status) |=> rx_wake_r)
        else $error("wake flag lost");
    rx_clear_a: assert property (@(posedge CLK) disable iff (RESET) // RL3
        (CLK_EN && wr_peripheral_config_status && !SFR_WDATA[PMCR_BIT_RX_WAKE]
         && !RX_WAKE_EVENT) |=> !rx_wake_r)
        else $error("wake flag not cleared");
    rail_src_a: assert property (@(posedge CLK) disable iff (RESET) // RL4
        CLK_EN |=> rail_r == $past(RAIL_ON_MAIN))
        else $error("rail source not sampled");
    supply_ok_a: assert property (@(posedge CLK) disable iff (RESET) // RL5
        CLK_EN |=> supply_ok_r == $past(MAIN_SUPPLY_OK))
        else $error("supply good not sampled");
    policy_off_a: assert property (@(posedge CLK) disable iff (RESET) // RL1
        policy_r[1] |-> !SWITCH_ON_VDD && !SWITCH_ON_DC)
        else $error("switchover not disabled");
    rx_gpio_a: assert property (@(posedge CLK) disable iff (RESET) // RL9
        (RX_PIN_FUNC == PMCR_RX_GPIO) |-> !RX_IS_SERIAL && !RX_WAKE_EN)
        else $error("pin not general purpose");
    rx_nowake_a: assert property (@(posedge CLK) disable iff (RESET) // RL9
        (RX_PIN_FUNC == PMCR_RX_NO_WAKE) |-> RX_IS_SERIAL && !RX_WAKE_EN)
        else $error("receive without wake decode");
    rx_func_wr_a: assert property (@(posedge CLK) disable iff (RESET) // RL9
        (CLK_EN && wr_peripheral_config_status) |=> RX_PIN_FUNC == $past(SFR_WDATA[1:0]))
        else $error("pin function write lost");
    peripheral_config_status_rd_a: assert property (@(posedge CLK) disable iff (RESET) // RL4
        (SFR_ADDR == PMCR_OFS_PERIPHERAL_CONFIG_STATUS) |-> SFR_RDATA[3:2] == 2'h0
        && SFR_RDATA[PMCR_BIT_RAIL_SRC] == rail_r)
        else $error("peripheral read wrong");

    // Interrupt gating, one check per enable except switchover, plus the quiet case.
    irq_restored_a: assert property (@(posedge CLK) disable iff (RESET) // RL10
        (irq_en_r[PMCR_BIT_RESTORED] && RESTORED_FLAG) |-> MONITOR_IRQ)
        else $error("restored irq not raised");
    irq_sag_a: assert property (@(posedge CLK) disable iff (RESET) // RL11
        (irq_en_r[PMCR_BIT_SAG] && SAG_FLAG) |-> MONITOR_IRQ)
        else $error("sag irq not raised");
    irq_dc_a: assert property (@(posedge CLK) disable iff (RESET) // RL13
        (irq_en_r[PMCR_BIT_DC_MON] && DC_MON_FLAG) |-> MONITOR_IRQ)
        else $error("dc monitor irq not raised");
    irq_quiet_a: assert property (@(posedge CLK) disable iff (RESET) // RL19
        MONITOR_IRQ |-> (irq_en_r & {RESTORED_FLAG, 1'b0, SAG_FLAG, 3'h0,
                                     SWITCHOVER_FLAG, DC_MON_FLAG}) != 8'h00)
        else $error("irq without enabled flag");

    // Reset, clock freeze and scratch pad retention.
    rst_clear_a: assert property (@(posedge CLK) // RL1
        RESET |=> policy_r == PMCR_RST_POLICY && irq_en_r == PMCR_RST_IRQ_EN
        && !fault_r && !rx_wake_r)
        else $error("reset values wrong");
    freeze_a: assert property (@(posedge CLK) disable iff (RESET) // RL15
        !CLK_EN |=> policy_r == $past(policy_r) && fault_r == $past(fault_r))
        else $error("state moved while frozen");
    scratch_wr_a: assert property (@(posedge CLK) // RL15
        (CLK_EN && wr_s1 && !SUPPLY_LOSS_RST)
        |=> retained_scratch_one_r == $past(SFR_WDATA))
        else $error("scratch write lost");
    scratch_rd_a: assert property (@(posedge CLK) // RL15
        (SFR_ADDR == PMCR_OFS_RETAINED_SCRATCH_TWO) |-> SFR_RDATA == retained_scratch_two_r)
        else $error("scratch read wrong");
    retained_scratch_two_keep_a: assert property (@(posedge CLK) // RL16
        (RESET && !SUPPLY_LOSS_RST) |=> retained_scratch_two_r == $past(retained_scratch_two_r))
        else $error("second scratch changed by reset");
    scratch_clr_a: assert property (@(posedge CLK) // RL16
        SUPPLY_LOSS_RST |=> retained_scratch_one_r == PMCR_RST_SCRATCH
        && retained_scratch_two_r == PMCR_RST_SCRATCH)
        else $error("scratch not cleared on supply loss");

endmodule

// ===== bench/pmcr_tb.sv
// Purpose: Self-checking bench for the power-management register bank.
// Assumes: Writes are one-cycle strobes; read data settles before negedge.
// Notes:   Status bits 6 and 5 lag their inputs, so the bench waits.
`timescale 1ns/1ps
module testbench;
    import pmcr_pkg::*;

    // ************************************************************
    // Stimulus signals
    // ************************************************************
    logic       clk     = 1'b0;
    logic       rst     = 1'b1;
    logic       clk_en  = 1'b1;
    logic       sup_rst = 1'b1;
    logic [7:0] addr    = 8'h00;
    logic       wen     = 1'b0;
    logic [7:0] wdat    = 8'h00;
    logic [7:0] rdata;
    logic       rx_ev   = 1'b0;
    logic       rail    = 1'b1;
    logic       sup_ok  = 1'b1;
    logic       lost    = 1'b0;
    logic       ack     = 1'b0;
    logic [3:0] flg     = 4'h0;
    logic [1:0] pol, rxf;
    logic       on_vdd, on_dc, rx_ser, rx_wk, irq;
    int         n_fail  = 0;
    int         cmp_count = 0;

    // Half period of 25 ns gives the 20 MHz core clock.
    always #25 clk = ~clk;

    pmcr_regs u_pmcr_regs (.CLK(clk), .RESET(rst), .CLK_EN(clk_en),
        .SUPPLY_LOSS_RST(sup_rst), .SFR_ADDR(addr), .SFR_WR(wen),
        .SFR_WDATA(wdat), .SFR_RDATA(rdata), .RX_WAKE_EVENT(rx_ev),
        .RAIL_ON_MAIN(rail), .MAIN_SUPPLY_OK(sup_ok), .LOCK_LOST(lost),
        .FAULT_ACK(ack), .RESTORED_FLAG(flg[3]), .SAG_FLAG(flg[2]),
        .SWITCHOVER_FLAG(flg[1]), .DC_MON_FLAG(flg[0]),
        .SWITCH_POLICY(pol), .SWITCH_ON_VDD(on_vdd), .SWITCH_ON_DC(on_dc),
        .RX_PIN_FUNC(rxf), .RX_IS_SERIAL(rx_ser), .RX_WAKE_EN(rx_wk),
        .MONITOR_IRQ(irq));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // The strobe drops for one edge between writes, as the bus pulses it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wen  <= 1'b1;
        @(posedge clk);
        wen  <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        @(negedge clk);
        chk(rdata, exp);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        rchk(PMCR_OFS_IRQ_EN, 8'h00);
        rchk(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, 8'h60);
        rchk(PMCR_OFS_POLICY, 8'h00);
        rchk(PMCR_OFS_RETAINED_SCRATCH_ONE, 8'h00);
        rchk(PMCR_OFS_RETAINED_SCRATCH_TWO, 8'h00);
        rchk(8'h10, 8'h00);
        $display("reset test done");
    endtask

    // Software keeps the upper bits zero, so only the field is written.
    task automatic t_policy;
        for (int i = 0; i < 4; i++) begin
            wr(PMCR_OFS_POLICY, {6'h00, 2'(i)});
            rchk(PMCR_OFS_POLICY, {6'h00, 2'(i)});
            chk({4'h0, pol, on_vdd, on_dc},
                {4'h0, 2'(i), ~i[1], i == 1});
        end
        $display("policy test done");
    endtask

    task automatic t_rx;
        logic [1:0] c;
        for (int i = 0; i < 3; i++) begin
            c = (i == 2) ? 2'h3 : 2'(i);
            wr(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, {6'h00, c});
            rchk(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, {6'h18, c});
            chk({4'h0, rxf, rx_ser, rx_wk},
                {4'h0, c, c != 2'h0, c == 2'h3});
        end
        $display("rx function test done");
    endtask

    task automatic t_status;
        @(posedge clk);
        rail   <= 1'b0;
        sup_ok <= 1'b0;
        wait_n(3);
        rchk(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, 8'h03);
        @(posedge clk);
        rail   <= 1'b1;
        sup_ok <= 1'b1;
        rx_ev  <= 1'b1;
        lost   <= 1'b1;
        @(posedge clk);
        rx_ev  <= 1'b0;
        lost   <= 1'b0;
        wait_n(3);
        rchk(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, 8'hf3);
        wr(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, 8'h03);
        rchk(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, 8'h73);
        // A lone acknowledge clears the fault.
        @(posedge clk);
        ack  <= 1'b1;
        @(posedge clk);
        ack  <= 1'b0;
        rchk(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, 8'h63);
        // Acknowledge and a fresh lock loss on one edge: the set wins.
        @(posedge clk);
        ack  <= 1'b1;
        lost <= 1'b1;
        @(posedge clk);
        ack  <= 1'b0;
        lost <= 1'b0;
        rchk(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, 8'h73);
        @(posedge clk);
        ack  <= 1'b1;
        @(posedge clk);
        ack  <= 1'b0;
        rchk(PMCR_OFS_PERIPHERAL_CONFIG_STATUS, 8'h63);
        $display("status test done");
    endtask

    task automatic t_irq;
        logic [7:0] en [4] = '{8'h01, 8'h02, 8'h20, 8'h80};
        // Bits 4..2 stay clear; reserved bit 6 must not be stored.
        wr(PMCR_OFS_IRQ_EN, 8'he3);
        rchk(PMCR_OFS_IRQ_EN, PMCR_MASK_IRQ_EN);
        for (int k = 0; k < 4; k++) begin
            wr(PMCR_OFS_IRQ_EN, en[k]);
            @(posedge clk);
            flg <= 4'(1 << k);
            @(negedge clk);
            chk({7'h0, irq}, 8'h01);
            @(posedge clk);
            flg <= ~4'(1 << k);
            @(negedge clk);
            chk({7'h0, irq}, 8'h00);
        end
        @(posedge clk);
        flg <= 4'h0;
        $display("interrupt test done");
    endtask

    // A frozen clock stands in for power saving; RESET must spare pads.
    task automatic t_scratch;
        wr(PMCR_OFS_RETAINED_SCRATCH_ONE, 8'ha5);
        wr(PMCR_OFS_RETAINED_SCRATCH_TWO, 8'h5a);
        clk_en <= 1'b0;
        wr(PMCR_OFS_RETAINED_SCRATCH_ONE, 8'h00);
        clk_en <= 1'b1;
        rst    <= 1'b1;
        wait_n(2);
        rst    <= 1'b0;
        rchk(PMCR_OFS_RETAINED_SCRATCH_ONE, 8'ha5);
        rchk(PMCR_OFS_RETAINED_SCRATCH_TWO, 8'h5a);
        rchk(PMCR_OFS_POLICY, 8'h00);
        @(posedge clk);
        sup_rst <= 1'b1;
        wait_n(2);
        sup_rst <= 1'b0;
        rchk(PMCR_OFS_RETAINED_SCRATCH_ONE, 8'h00);
        $display("scratch test done");
    endtask

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // The whole run needs about a hundred cycles; this bound is generous.
    initial begin
        wait_n(5000);
        n_fail++;
        wrap_up();
    end

    initial begin
        wait_n(12);
        rst     <= 1'b0;
        sup_rst <= 1'b0;
        t_reset();
        t_policy();
        t_rx();
        t_status();
        t_irq();
        t_scratch();
        wrap_up();
    end
endmodule
